/* verilog/config_storage_element_set_reset.sv */
// Logic block with two configurable storage elements and Avalon registers
`timescale 1ns/10ps
`default_nettype none

module config_storage_element_set_reset
  import storage_element_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  // Avalon-MM slave
  input  wire logic [ADDR_WIDTH-1:0]   address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [DATA_WIDTH-1:0]   writedata,
  input  wire logic [3:0]              byteenable,
  output logic      [DATA_WIDTH-1:0]   readdata,
  output logic                         waitrequest,
  // Global set/reset pin and dedicated reset net, both asynchronous
  input  wire logic                    globalSetResetPin,
  input  wire logic                    dedicatedResetPin,
  // On-chip user logic, same clock
  input  wire logic                    localSetReset,
  input  wire logic                    clockEnable,
  input  wire logic [ELEMENT_COUNT-1:0] dataIn,
  output logic      [ELEMENT_COUNT-1:0] q
);

  // ******************************************************
  // Helper functions
  // ******************************************************
  // True when the bus address selects the given register word
  function automatic logic addressHit
  (
    input logic [ADDR_WIDTH-1:0] addr,
    input logic [ADDR_WIDTH-1:0] offset
  );
    addressHit = (addr[ADDR_WIDTH-1:2] == offset[ADDR_WIDTH-1:2]);
  endfunction

  // ******************************************************
  // Declarations
  // ******************************************************
  bus_state_type                busState;        // Bus answer sequencer
  bus_state_type                next_busState;   // Its next value
  logic                         accept;          // Access completes now
  logic [CONFIG_WIDTH-1:0]      configBits;      // Element options
  logic                         configDone;      // Configuration complete
  logic                         globalPulse;     // Software global pulse
  logic [1:0]                   globalSync;      // Global pin synchroniser
  logic [1:0]                   dedicatedSync;   // Reset net synchroniser
  logic                         globalForce;     // Combined global force
  logic [DATA_WIDTH-1:0]        next_readdata;   // Read mux
  logic [ELEMENT_COUNT-1:0]     elementQ;        // Element outputs

  // ******************************************************
  // Avalon sequencing
  // ******************************************************
  // Every access takes exactly one wait cycle; read data is formed
  // in that cycle so it sits in a flop when waitrequest drops
  always_comb
  begin
    next_busState = busState;
    case (busState)
      BUS_IDLE:
      begin
        // Any request moves to the answer cycle
        if (read || write)
        begin
          next_busState = BUS_ANSWER;
        end
      end
      BUS_ANSWER:
      begin
        // Master releases or starts anew after this edge
        next_busState = BUS_IDLE;
      end
      default:
      begin
        next_busState = BUS_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      busState <= BUS_IDLE;
    end
    else
    begin
      busState <= next_busState;
    end
  end

  // Handshake may be combinational
  assign accept      = (busState == BUS_ANSWER) && (read || write);
  assign waitrequest = (read || write) && (busState != BUS_ANSWER);

  // ******************************************************
  // Configuration register
  // ******************************************************
  // Options live in byte lane 0; other lanes hold nothing
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      configBits <= CONFIG_RESET;
    end
    else if (accept && write && byteenable[0]
             && addressHit(address, OFFSET_CONFIG))
    begin
      // One bit per element picks its set or reset state
      configBits <= writedata[CONFIG_WIDTH-1:0];
    end
  end

  // ******************************************************
  // Control register
  // ******************************************************
  // Completion flag; clearing it re-enters configuration
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      configDone <= 1'b0;
    end
    else if (accept && write && byteenable[0]
             && addressHit(address, OFFSET_CONTROL))
    begin
      configDone <= writedata[CTRL_DONE];
    end
  end

  // Write of 1 to the global bit gives a one-cycle global pulse
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      globalPulse <= 1'b0;
    end
    else
    begin
      globalPulse <= accept && write && byteenable[0]
                     && addressHit(address, OFFSET_CONTROL)
                     && writedata[CTRL_GLOBAL];
    end
  end

  // ******************************************************
  // Pin synchronisers
  // ******************************************************
  // Pins arrive from outside the clock domain; only stage 1 is read
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      globalSync    <= 2'h0;
      dedicatedSync <= 2'h0;
    end
    else
    begin
      globalSync    <= {globalSync[0], globalSetResetPin};
      dedicatedSync <= {dedicatedSync[0], dedicatedResetPin};
    end
  end

  // ******************************************************
  // Global force
  // ******************************************************
  // Held active throughout configuration so every element leaves it
  // in its configured state; also the pin, reset net and software
  assign globalForce = !configDone
                     | dedicatedSync[1]
                     | globalSync[1]
                     | globalPulse;

  // ******************************************************
  // Storage elements
  // ******************************************************
  // Both elements share the local set/reset and clock enable of the
  // block, but each has its own polarity, enable and mode
  genvar i;
  generate
    for (i = 0; i < ELEMENT_COUNT; i++)
    begin : elementSlot
      storage_element_if link ();

      assign link.initState     = configBits[CFG_INIT_LSB + i];
      assign link.srEnable      = configBits[CFG_SREN_LSB + i];
      assign link.mode          = configBits[CFG_LATCH_LSB + i]
                                  ? MODE_LATCH
                                  : MODE_FLIP_FLOP;
      assign link.globalForce   = globalForce;
      assign link.localSetReset = localSetReset;
      assign link.clockEnable   = clockEnable;
      assign link.dataIn        = dataIn[i];
      assign elementQ[i]        = link.q;

      storage_element element
      (
        .clk_sys (clk_sys),
        .reset   (reset),
        .port    (link)
      );
    end
  endgenerate

  // Output follows the element so a force is seen at once
  assign q = elementQ;

  // ******************************************************
  // Read data
  // ******************************************************
  // Unmapped words read as zero
  always_comb
  begin
    next_readdata = '0;
    if (addressHit(address, OFFSET_CONFIG))
    begin
      next_readdata[CONFIG_WIDTH-1:0] = configBits;
    end
    else if (addressHit(address, OFFSET_CONTROL))
    begin
      next_readdata[CTRL_DONE] = configDone;
    end
    else if (addressHit(address, OFFSET_STATUS))
    begin
      next_readdata[STAT_Q_LSB +: ELEMENT_COUNT] = elementQ;
      next_readdata[STAT_DONE]                   = configDone;
      next_readdata[STAT_GLOBAL]                 = globalForce;
    end
  end

  // Captured in the wait cycle, stable through the answer edge
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      readdata <= '0;
    end
    else if (read && busState == BUS_IDLE)
    begin
      readdata <= next_readdata;
    end
  end

endmodule

`default_nettype wire

/* verilog/storage_element_pkg.sv */
// Shared constants and types for the logic block storage element design
package storage_element_pkg;

  // ******************************************************
  // Register bus geometry
  // ******************************************************
  localparam int unsigned ADDR_WIDTH = 4;   // Byte address, four words
  localparam int unsigned DATA_WIDTH = 32;  // Avalon data width

  // Register byte offsets
  localparam logic [3:0] OFFSET_CONFIG  = 4'h0;
  localparam logic [3:0] OFFSET_CONTROL = 4'h4;
  localparam logic [3:0] OFFSET_STATUS  = 4'h8;

  // ******************************************************
  // Configuration register fields
  // ******************************************************
  localparam int unsigned ELEMENT_COUNT = 2;  // Two elements per block
  localparam int unsigned CONFIG_WIDTH  = 6;
  localparam int unsigned CFG_INIT_LSB  = 0;  // Bits 1:0, 1 = set
  localparam int unsigned CFG_SREN_LSB  = 2;  // Bits 3:2, 1 = enabled
  localparam int unsigned CFG_LATCH_LSB = 4;  // Bits 5:4, 1 = latch
  // Local set/reset enabled, reset polarity, flip-flop mode
  localparam logic [5:0]  CONFIG_RESET  = 6'h0c;

  // ******************************************************
  // Control and status fields
  // ******************************************************
  localparam int unsigned CTRL_DONE    = 0;  // Configuration complete
  localparam int unsigned CTRL_GLOBAL  = 1;  // Write 1: global pulse
  localparam int unsigned STAT_Q_LSB   = 0;  // Bits 1:0, element outputs
  localparam int unsigned STAT_DONE    = 2;  // Configuration complete
  localparam int unsigned STAT_GLOBAL  = 3;  // Global force active now

  // ******************************************************
  // Types
  // ******************************************************
  typedef enum logic [1:0]
  {
    MODE_FLIP_FLOP = 2'b01,
    MODE_LATCH     = 2'b10
  } mode_type;

  typedef enum logic [1:0]
  {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_type;

endpackage

/* verilog/storage_element_if.sv */
// Carrier between the logic block control and one storage element
`timescale 1ns/10ps
`default_nettype none

interface storage_element_if;
  import storage_element_pkg::*;

  logic     initState;      // Configured state, 1 = set, 0 = reset
  logic     srEnable;       // Local set/reset honoured when high
  mode_type mode;           // Flip-flop or transparent latch
  logic     globalForce;    // Global set/reset net, active high
  logic     localSetReset;  // Local set/reset input, active high
  logic     clockEnable;    // Clock enable, or latch gate
  logic     dataIn;         // Data input
  logic     q;              // Element output

  // Control side drives configuration and inputs
  modport control
  (
    output initState, srEnable, mode, globalForce,
    output localSetReset, clockEnable, dataIn,
    input  q
  );

  // Element side obeys them
  modport element
  (
    input  initState, srEnable, mode, globalForce,
    input  localSetReset, clockEnable, dataIn,
    output q
  );

endinterface

`default_nettype wire

/* verilog/storage_element.sv */
// One configurable storage element: flip-flop or latch with set/reset
`timescale 1ns/10ps
`default_nettype none

module storage_element
  import storage_element_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            reset,
  storage_element_if.element   port
);

  // ******************************************************
  // Force decode
  // ******************************************************
  logic forceActive;  // Any set/reset asserted on this element
  logic stored;       // Held state

  // Global always acts; local only when enabled for this element,
  // and it is taken active high with no inversion possible
  assign forceActive = port.globalForce
                     | (port.srEnable & port.localSetReset);

  // ******************************************************
  // State update
  // ******************************************************
  // Set/reset outranks loading; the enable gates every load
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      stored <= 1'b0;
    end
    else if (forceActive)
    begin
      // Same state for global and local forces
      stored <= port.initState;
    end
    else if (port.clockEnable)
    begin
      // Edge load, or last value seen while the latch gate was open
      stored <= port.dataIn;
    end
  end

  // ******************************************************
  // Output
  // ******************************************************
  // Combinational so a force shows without waiting for a clock edge;
  // the price is a path from set/reset through to the output
  always_comb
  begin
    if (forceActive)
    begin
      port.q = port.initState;
    end
    else if (port.mode == MODE_LATCH && port.clockEnable)
    begin
      port.q = port.dataIn;  // Transparent latch
    end
    else
    begin
      port.q = stored;  // Flip-flop, or closed latch
    end
  end

endmodule

`default_nettype wire

/* testbench/config_storage_element_set_reset_properties.sv */
// Port-level properties of the storage element block
`timescale 1ns/10ps
`default_nettype none

module config_storage_element_set_reset_properties
  import storage_element_pkg::*;
(
  input wire logic                     clk_sys,
  input wire logic                     reset,
  input wire logic [ADDR_WIDTH-1:0]    address,
  input wire logic                     read,
  input wire logic                     write,
  input wire logic [DATA_WIDTH-1:0]    writedata,
  input wire logic [3:0]               byteenable,
  input wire logic [DATA_WIDTH-1:0]    readdata,
  input wire logic                     waitrequest,
  input wire logic                     globalSetResetPin,
  input wire logic                     dedicatedResetPin,
  input wire logic                     localSetReset,
  input wire logic                     clockEnable,
  input wire logic [ELEMENT_COUNT-1:0] dataIn,
  input wire logic [ELEMENT_COUNT-1:0] q
);
  // ****************************************
  // Shadow state seen from the bus
  // ****************************************
  logic [5:0] cfg;    // Configuration copy
  logic       done;   // Configuration complete copy
  logic [2:0] quiet;  // Cycles since any global source, saturates at 4
  logic       wrDone; // Write taking effect at this edge
  assign wrDone = write && !waitrequest && byteenable[0];
  // Track register writes at the edge where they land
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cfg <= CONFIG_RESET;
      done <= 1'b0;
    end
    else if (wrDone && address[3:2] == OFFSET_CONFIG[3:2])
      cfg <= writedata[5:0];
    else if (wrDone && address[3:2] == OFFSET_CONTROL[3:2])
      done <= writedata[CTRL_DONE];
  end
  // Quiet time keeps sync delays of the pins out of the element checks
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      quiet <= 3'h0;
    else if (globalSetResetPin || dedicatedResetPin ||
             (wrDone && address[3:2] == OFFSET_CONTROL[3:2] &&
              writedata[CTRL_GLOBAL]))
      quiet <= 3'h0;
    else if (quiet != 3'h4)
      quiet <= quiet + 3'h1;
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // Each property is declared before the assertion that uses it
  property p_wait;
    $rose(read || write) |-> waitrequest ##1 !waitrequest;
  endproperty
  a_wait: assert property (p_wait)
    else $error("waitrequest not one cycle");
  property p_unmapped;
    read && !waitrequest && address[3:2] == 2'h3 |-> readdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_config_hold;
    !done && !$past(done) |-> q == cfg[1:0];
  endproperty
  a_config_hold: assert property (p_config_hold)
    else $error("output not held before configuration done");
  property p_local;
    localSetReset |-> (!cfg[2] || q[0] == cfg[0]) &&
                      (!cfg[3] || q[1] == cfg[1]);
  endproperty
  a_local: assert property (p_local)
    else $error("local set/reset did not force state");
  property p_sr_off;
    done && quiet == 3'h4 && cfg[5:3] == 3'h0 && localSetReset &&
    !$past(clockEnable) && !$past(write) |-> q[1] == $past(q[1]);
  endproperty
  a_sr_off: assert property (p_sr_off)
    else $error("disabled element obeyed local set/reset");
  property p_pins;
    $rose(globalSetResetPin) || $rose(dedicatedResetPin)
      |-> ##2 q == cfg[1:0];
  endproperty
  a_pins: assert property (p_pins)
    else $error("global pin did not force state");
  property p_ff_load;
    done && quiet == 3'h4 && !cfg[4] && !write && clockEnable &&
    !(localSetReset && cfg[2])
      |=> (localSetReset && cfg[2]) || q[0] == $past(dataIn[0]);
  endproperty
  a_ff_load: assert property (p_ff_load)
    else $error("flip-flop did not load data");
  property p_ce_hold;
    done && quiet == 3'h4 && !cfg[4] && !write && !clockEnable &&
    !(localSetReset && cfg[2])
      |=> (localSetReset && cfg[2]) || q[0] == $past(q[0]);
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("flip-flop changed with enable low");
  property p_latch;
    done && quiet == 3'h4 && cfg[5:4] == 2'h3 && clockEnable &&
    !localSetReset |-> q == dataIn;
  endproperty
  a_latch: assert property (p_latch)
    else $error("open latch not transparent");
endmodule

bind config_storage_element_set_reset
  config_storage_element_set_reset_properties props
  (.clk_sys, .reset, .address, .read, .write, .writedata, .byteenable,
   .readdata, .waitrequest, .globalSetResetPin, .dedicatedResetPin,
   .localSetReset, .clockEnable, .dataIn, .q);

`default_nettype wire

/* testbench/user_logic_model.sv */
// Behavioural model of the user logic feeding the block
`timescale 1ns/10ps
`default_nettype none

module user_logic_model
  import storage_element_pkg::*;
(
  input  wire logic                     clk_sys,
  output logic                          localSetReset,
  output logic                          clockEnable,
  output logic [ELEMENT_COUNT-1:0]      dataIn
);
  // Known levels from time zero so nothing floats into the block
  initial
  begin
    localSetReset = 1'b0;
    clockEnable = 1'b0;
    dataIn = '0;
  end
  // Same-clock logic changes just after a rising edge
  task automatic drive(input logic s, input logic e, input logic [1:0] d);
    @(posedge clk_sys);
    localSetReset <= s;
    clockEnable <= e;
    dataIn <= d;
  endtask
endmodule

`default_nettype wire

/* testbench/config_storage_element_set_reset_tb_top.sv */
// Self-checking bench for the storage element block
`timescale 1ns/10ps
`default_nettype none

module config_storage_element_set_reset_tb_top;
  import storage_element_pkg::*;
  logic        clk_sys;
  logic        reset;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [1:0]  pins;          // Global pin, dedicated reset pin
  logic        localSetReset;
  logic        clockEnable;
  logic [1:0]  dataIn;
  logic [1:0]  q;
  int          n_fail;
  int          checks_done;

  config_storage_element_set_reset dut
  (.clk_sys, .reset, .address, .read, .write, .writedata, .byteenable,
   .readdata, .waitrequest, .globalSetResetPin(pins[0]),
   .dedicatedResetPin(pins[1]), .localSetReset, .clockEnable, .dataIn,
   .q);
  user_logic_model user
  (.clk_sys, .localSetReset, .clockEnable, .dataIn);

  // ****************************************
  // Clock, verdict and comparison
  // ****************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop();
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string s, input logic [31:0] v,
                       input logic [31:0] e);
    checks_done++;
    if (v !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", s, e, v);
    end
  endtask
  // Output check once the launching edge has settled
  task automatic qc(input logic [1:0] e, input string s);
    #1;
    check(s, 32'(q), 32'(e));
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] rd);
    int n;
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= w;
    read <= !w;
    n = 0;
    @(posedge clk_sys);
    // Waitrequest is seen at the edge itself, before that edge's
    // updates land; the answer edge is the one that sees it low
    while (waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    // Read data stand at the answer edge; release only after it
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (waitrequest !== 1'b0)
    begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, 4'hf, x);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e,
                     input string s);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, 4'hf, x);
    check(s, x, e);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    logic [1:0]  init;
    logic [31:0] x;
    n_fail = 0;
    checks_done = 0;
    reset = 1'b1;
    {read, write, address, writedata, byteenable, pins} = '0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rdc(OFFSET_CONFIG, 32'h0000_000c, "config reset");
    rdc(OFFSET_STATUS, 32'h0000_0008, "status reset");
    rdc(4'hc, 32'h0000_0000, "unmapped read");
    bus(1'b1, OFFSET_CONFIG, 32'h0000_003f, 4'he, x);
    wr(4'hc, 32'h0000_ffff);
    rdc(OFFSET_CONFIG, 32'h0000_000c, "lane zero write");
    // Every set/reset choice through the local, software and both pin force sources
    for (int i = 0; i < 4; i++)
    begin
      init = 2'(i);
      wr(OFFSET_CONFIG, {28'h000_0000, 2'h3, init});
      wr(OFFSET_CONTROL, 32'h0000_0001);
      user.drive(1'b1, 1'b1, ~init);
      qc(init, "local force");
      @(posedge clk_sys);
      qc(init, "force over load");
      user.drive(1'b0, 1'b1, ~init);
      @(posedge clk_sys);
      qc(~init, "clocked load");
      user.drive(1'b0, 1'b0, init);
      @(posedge clk_sys);
      qc(~init, "enable low hold");
      wr(OFFSET_CONTROL, 32'h0000_0003);
      qc(init, "software global");
      for (int j = 0; j < 2; j++)
      begin
        user.drive(1'b0, 1'b1, ~init);
        user.drive(1'b0, 1'b0, init);
        @(posedge clk_sys);
        pins[j] <= 1'b1;
        repeat (3) @(posedge clk_sys);
        qc(init, "pin global");
        @(posedge clk_sys);
        pins[j] <= 1'b0;
        repeat (3) @(posedge clk_sys);
      end
    end
    // Element 1 ignores local set/reset when disabled
    wr(OFFSET_CONFIG, 32'h0000_0007);
    user.drive(1'b0, 1'b1, 2'h0);
    user.drive(1'b0, 1'b0, 2'h0);
    user.drive(1'b1, 1'b0, 2'h0);
    qc(2'h1, "local disabled");
    // Transparent latch, then gate closed
    wr(OFFSET_CONFIG, 32'h0000_003c);
    user.drive(1'b0, 1'b1, 2'h2);
    qc(2'h2, "latch open");
    user.drive(1'b0, 1'b0, 2'h2);
    user.drive(1'b0, 1'b0, 2'h1);
    qc(2'h2, "latch closed");
    rdc(OFFSET_CONTROL, 32'h0000_0001, "control readback");
    rdc(OFFSET_STATUS, 32'h0000_0006, "status running");
    wr(OFFSET_CONTROL, 32'h0000_0000);
    rdc(OFFSET_STATUS, 32'h0000_0008, "reconfigure");
    // Reset in mid-run restores the power-up configuration
    @(posedge clk_sys);
    reset <= 1'b1;
    @(posedge clk_sys);
    reset <= 1'b0;
    rdc(OFFSET_CONFIG, 32'h0000_000c, "config after reset");
    rdc(OFFSET_STATUS, 32'h0000_0008, "status after reset");
    report_and_stop();
  end
  // Run limit
  initial
  begin
    #100000;
    n_fail++;
    report_and_stop();
  end
endmodule

`default_nettype wire
